// file: verilog/cmef_flags.sv
`timescale 1ns/100ps
// Notes on behaviour
// R01 - Set flag bit 19 when a received frame lands in a dedicated buffer.
// R02 - Set RAM failure bit 17 when a new arbitration field arrives mid-storage.
// R03 - On that overrun, drop the current frame and start on the next one.
// R04 - Set RAM failure bit 17 and abort when a receive write to memory fails.
// R05 - Aborted storage leaves put index and buffer new-data indication untouched.
// R06 - A partly stored frame is overwritten by the next frame at that location.
// R07 - A late transmit fetch sets RAM failure bit 17 and aborts that transmission.
// R08 - A transmit memory failure puts the controller into restricted mode.
// R09 - Software leaves restricted mode by clearing the restricted-mode control bit.
// R10 - Set timestamp wrap bit 16 on each counter wrap; zero until one occurs.
// R11 - Set transmit event lost bit 15 when a transmit event element is lost.
// R12 - Also set bit 15 on a write attempt into a zero-size transmit event FIFO.
// R13 - Set transmit event full bit 14 when that FIFO becomes full.
// R14 - Flags reset to zero and stay set until software writes one to clear.
module cmef_flags
(
    // Clock and reset.
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite write channels.
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Handler events.
    input  wire cmef_pkg::cmef_evt_s evt,
    // Handler controls.
    output logic                     rx_abort,
    output logic                     rx_put_inc,
    output logic                     rx_new_data_set,
    output logic                     tx_abort,
    output logic                     restricted_mode_control,
    output logic                     irq
);
    import cmef_pkg::*;

    logic [31:0] flags_r;
    logic [31:0] mask_r;
    logic [5:0]  tef_size_r;
    logic [5:0]  rx_put_r;
    cmef_rx_e    rx_state_r;
    logic        rx_fail_r;
    logic        rx_ded_r;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic [31:0] set_nxt;
    logic [31:0] clr_nxt;
    logic [31:0] wmask;
    logic        wr_fire;
    logic        rx_overrun;
    logic        rx_commit;

    // Overrun: a new arbitration field while the previous frame is still open.
    assign rx_overrun = evt.rx_start && rx_state_r == RX_STORE; // [R02]
    assign rx_commit  = evt.rx_done && rx_state_r == RX_STORE && !rx_fail_r
                        && !evt.rx_write_fail;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_state_r <= RX_IDLE;
            rx_fail_r  <= 1'b0;
            rx_ded_r   <= 1'b0;
        end
        else
        begin
            unique case (rx_state_r)
                RX_IDLE:
                begin
                    if (evt.rx_start)
                    begin
                        rx_state_r <= RX_STORE;
                        rx_fail_r  <= 1'b0;
                        rx_ded_r   <= evt.rx_dedicated;
                    end
                end
                RX_STORE:
                begin
                    // The old frame is dropped and the new one taken on at once.
                    if (evt.rx_start) // [R03]
                    begin
                        rx_fail_r <= 1'b0;
                        rx_ded_r  <= evt.rx_dedicated;
                    end
                    else if (evt.rx_done)
                    begin
                        rx_state_r <= RX_IDLE;
                    end
                    else if (evt.rx_write_fail)
                    begin
                        rx_fail_r <= 1'b1; // [R04]
                    end
                end
            endcase
        end
    end

    // Put index only advances on a clean commit, so an aborted frame's slot is reused.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_put_r        <= RX_PUT_RST;
            rx_put_inc      <= 1'b0;
            rx_new_data_set <= 1'b0;
            rx_abort        <= 1'b0;
        end
        else
        begin
            rx_put_inc      <= rx_commit && !rx_ded_r; // [R05]
            rx_new_data_set <= rx_commit && rx_ded_r; // [R05]
            rx_abort        <= rx_overrun || (evt.rx_write_fail && rx_state_r == RX_STORE); // [R03] [R04]
            if (rx_commit && !rx_ded_r)
            begin
                rx_put_r <= rx_put_r + 6'h01; // [R06]
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_abort <= 1'b0;
        end
        else
        begin
            tx_abort <= evt.tx_fetch_late; // [R07]
        end
    end

    always_comb
    begin
        set_nxt = 32'h0000_0000;
        set_nxt[DRX_BIT]  = rx_commit && rx_ded_r; // [R01]
        set_nxt[TOO_BIT]  = evt.timeout;
        set_nxt[MRF_BIT]  = rx_overrun || (evt.rx_write_fail && rx_state_r == RX_STORE)
                            || evt.tx_fetch_late; // [R02] [R04] [R07]
        set_nxt[TSW_BIT]  = evt.ts_wrap; // [R10]
        set_nxt[TX_EVENT_ELEMENT_LOST_FLAG_BIT] = evt.tef_lost || (evt.tef_write && tef_size_r == 6'h00); // [R11] [R12]
        set_nxt[TX_EVENT_QUEUE_FULL_FLAG_BIT] = evt.tef_full && tef_size_r != 6'h00; // [R13]
    end

    // AXI write side: address and data are latched independently.
    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    always_comb
    begin
        wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    end

    always_comb
    begin
        clr_nxt = 32'h0000_0000;
        if (wr_fire && awaddr_r == FLAGS_OFS)
        begin
            clr_nxt = wdata_r & wmask & FLAG_BITS;
        end
    end

    // A set arriving in the clearing cycle wins, so no event is lost.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flags_r <= FLAGS_RST; // [R14]
        end
        else
        begin
            flags_r <= (flags_r & ~clr_nxt) | set_nxt; // [R14]
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            awaddr_r      <= 8'h00;
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_r == FLAGS_OFS || awaddr_r == MASK_OFS || awaddr_r == CONFIG_OFS
                                 || awaddr_r == STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration: restricted mode is entered by hardware, left only by software.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mask_r                  <= MASK_RST;
            tef_size_r              <= TEF_SIZE_RST;
            restricted_mode_control <= 1'b0;
        end
        else
        begin
            if (wr_fire && awaddr_r == MASK_OFS)
            begin
                mask_r <= ((mask_r & ~wmask) | (wdata_r & wmask)) & FLAG_BITS;
            end
            if (evt.tx_fetch_late)
            begin
                restricted_mode_control <= 1'b1; // [R08]
            end
            else if (wr_fire && awaddr_r == CONFIG_OFS && wstrb_r[0])
            begin
                restricted_mode_control <= wdata_r[CFG_RESTRICT_BIT]; // [R09]
            end
            if (wr_fire && awaddr_r == CONFIG_OFS && wstrb_r[1])
            begin
                tef_size_r <= wdata_r[CFG_TEF_SIZE_LSB +: 6];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(flags_r & mask_r);
        end
    end

    // AXI read side: one read at a time, answered two cycles after arvalid.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                unique case (s_axi_araddr)
                    FLAGS_OFS:  s_axi_rdata <= flags_r;
                    MASK_OFS:   s_axi_rdata <= mask_r;
                    CONFIG_OFS: s_axi_rdata <= {18'h0, tef_size_r, 7'h00, restricted_mode_control};
                    STATUS_OFS: s_axi_rdata <= {22'h0, (rx_state_r == RX_STORE), restricted_mode_control,
                                                2'h0, rx_put_r};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    sequence s_late_fetch;
        evt.tx_fetch_late;
    endsequence

    sequence s_restricted_and_failed;
        restricted_mode_control && flags_r[MRF_BIT];
    endsequence

    AST_DRX_SET: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
        rx_commit && rx_ded_r |=> flags_r[DRX_BIT] && rx_new_data_set)
        else $error("Dedicated buffer flag not set after store.");
    AST_OVERRUN_MRF: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
        rx_overrun |=> flags_r[MRF_BIT] && rx_abort)
        else $error("Overrun did not raise RAM failure.");
    AST_OVERRUN_NEXT: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
        rx_overrun |=> rx_state_r == RX_STORE && !rx_fail_r)
        else $error("Receive handler did not take the next frame.");
    AST_WFAIL_MRF: assert property (@(posedge aclk) disable iff (!aresetn) // [R04]
        evt.rx_write_fail && rx_state_r == RX_STORE |=> flags_r[MRF_BIT])
        else $error("Write failure did not raise RAM failure.");
    AST_ABORT_NO_PUT: assert property (@(posedge aclk) disable iff (!aresetn) // [R05]
        rx_fail_r && evt.rx_done |=> !rx_put_inc && !rx_new_data_set && $stable(rx_put_r))
        else $error("Aborted frame advanced index or new-data.");
    AST_TX_RESTRICT: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
        s_late_fetch |=> s_restricted_and_failed ##0 tx_abort)
        else $error("Late fetch did not abort and restrict.");
    AST_RESTRICT_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // [R09]
        restricted_mode_control && !(wr_fire && awaddr_r == CONFIG_OFS) |=> restricted_mode_control)
        else $error("Restricted mode left without software.");
    AST_TSW_SET: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
        evt.ts_wrap |=> flags_r[TSW_BIT])
        else $error("Timestamp wrap flag missing.");
    AST_TX_EVENT_ELEMENT_LOST_FLAG_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
        evt.tef_write && tef_size_r == 6'h00 |=> flags_r[TX_EVENT_ELEMENT_LOST_FLAG_BIT])
        else $error("Zero-size event write did not set lost flag.");
    AST_TX_EVENT_QUEUE_FULL_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
        evt.tef_full && tef_size_r != 6'h00 |=> flags_r[TX_EVENT_QUEUE_FULL_FLAG_BIT])
        else $error("Event queue full flag missing.");
    AST_STICKY: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
        flags_r[TOO_BIT] && !clr_nxt[TOO_BIT] |=> flags_r[TOO_BIT])
        else $error("Flag dropped without a clear.");
endmodule

// file: verilog/cmef_pkg.sv
package cmef_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] FLAGS_OFS        = 8'h00;
    localparam logic [7:0] MASK_OFS         = 8'h04;
    localparam logic [7:0] CONFIG_OFS       = 8'h08;
    localparam logic [7:0] STATUS_OFS       = 8'h0c;

    // Flag bit positions in the event flag and mask registers.
    localparam int DRX_BIT                  = 19;
    localparam int TOO_BIT                  = 18;
    localparam int MRF_BIT                  = 17;
    localparam int TSW_BIT                  = 16;
    localparam int TX_EVENT_ELEMENT_LOST_FLAG_BIT                 = 15;
    localparam int TX_EVENT_QUEUE_FULL_FLAG_BIT                 = 14;
    localparam logic [31:0] FLAG_BITS       = 32'h000f_c000;

    // Field positions in the configuration and status registers.
    localparam int CFG_RESTRICT_BIT         = 0;
    localparam int CFG_TEF_SIZE_LSB         = 8;
    localparam int STS_RX_PUT_LSB           = 0;
    localparam int STS_RESTRICT_BIT         = 8;
    localparam int STS_RX_BUSY_BIT          = 9;

    // Reset values.
    localparam logic [31:0] FLAGS_RST       = 32'h0000_0000;
    localparam logic [31:0] MASK_RST        = 32'h0000_0000;
    localparam logic [5:0]  TEF_SIZE_RST    = 6'h00;
    localparam logic [5:0]  RX_PUT_RST      = 6'h00;

    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    // Receive handler storage state.
    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_STORE = 2'b01
    } cmef_rx_e;

    // Events reported by the handlers and the timestamp logic.
    typedef struct packed
    {
        logic rx_start;
        logic rx_done;
        logic rx_dedicated;
        logic rx_write_fail;
        logic timeout;
        logic ts_wrap;
        logic tx_fetch_late;
        logic tef_write;
        logic tef_lost;
        logic tef_full;
    } cmef_evt_s;

endpackage

// file: verification/cmef_handler_model.sv
`timescale 1ns/100ps
// Stand-in for the receive, transmit and timestamp handlers. It issues one-cycle
// event pulses and counts the rx_abort, rx_new_data_set and tx_abort pulses that the flag block sends back.
module cmef_handler_model
(
    // Clock and reset.
    input  wire logic           aclk,
    input  wire logic           aresetn,
    // Controls from the flag block.
    input  wire logic           rx_abort,
    input  wire logic           rx_new_data_set,
    input  wire logic           tx_abort,
    // Events to the flag block.
    output cmef_pkg::cmef_evt_s evt
);
    import cmef_pkg::*;

    int abort_cnt;
    int new_data_cnt;
    int tx_abort_cnt;

    initial evt = '0;

    // Counters restart with the block so a second reset starts a clean tally.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            abort_cnt    <= 0;
            new_data_cnt <= 0;
            tx_abort_cnt <= 0;
        end
        else
        begin
            abort_cnt    <= abort_cnt + int'(rx_abort);
            new_data_cnt <= new_data_cnt + int'(rx_new_data_set);
            tx_abort_cnt <= tx_abort_cnt + int'(tx_abort);
        end
    end

    // One pulse, then a quiet cycle, so back-to-back calls never merge.
    task automatic fire(input logic [9:0] v);
        @(posedge aclk);
        evt <= cmef_evt_s'(v);
        @(posedge aclk);
        evt <= '0;
    endtask
endmodule

// file: verification/cmef_flags_tb.sv
`timescale 1ns/100ps
module cmef_flags_tb;
    import cmef_pkg::*;

    logic        aclk = 1'b0;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    cmef_evt_s   evt;
    logic        rx_abort;
    logic        rx_put_inc;
    logic        rx_new_data_set;
    logic        tx_abort;
    logic        restricted_mode_control;
    logic        irq;
    int          mismatches = 0;
    int          comparisons = 0;
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [1:0]  bs;
    int          put_pulses = 0;

    always #12.5 aclk = ~aclk;

    // Tally of put index pulses, so the FIFO commit output is judged directly.
    always @(posedge aclk)
        put_pulses <= put_pulses + int'(rx_put_inc);

    cmef_flags i_cmef_flags (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .evt(evt), .rx_abort(rx_abort), .rx_put_inc(rx_put_inc),
        .rx_new_data_set(rx_new_data_set), .tx_abort(tx_abort),
        .restricted_mode_control(restricted_mode_control), .irq(irq));

    cmef_handler_model i_cmef_handler_model (.aclk(aclk), .aresetn(aresetn), .rx_abort(rx_abort),
        .rx_new_data_set(rx_new_data_set), .tx_abort(tx_abort), .evt(evt));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic hang(input string what);
        mismatches++;
        $display("[ERR] %0t %s never answered", $time, what);
        give_verdict();
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        // One edge first, so a ready dropped by the last call is never raised in the same step.
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready && !aw_done)
            begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_done)
            begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid)
            begin
                bs = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("write");
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("read");
    endtask

    task automatic flags_are(input logic [31:0] exp);
        axi_read(FLAGS_OFS, rd, rs);
        check(rd, exp, "flags");
    endtask

    task automatic test_reset_map();
        flags_are(FLAGS_RST);
        axi_read(MASK_OFS, rd, rs);
        check(rd, MASK_RST, "mask reset");
        axi_read(8'h40, rd, rs);
        check({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped resp");
        check(rd, 32'h0000_0000, "unmapped data");
        axi_write(8'h40, 32'h0000_0000);
        check({30'h0, bs}, {30'h0, RESP_SLVERR}, "unmapped write resp");
        $display("test reset and map done");
    endtask

    // Each plain event flag: sticky while masked, then irq once unmasked, then W1C.
    task automatic test_events();
        logic [9:0] ev [4] = '{10'h020, 10'h010, 10'h002, 10'h001};
        int         bt [4] = '{TOO_BIT, TSW_BIT, TX_EVENT_ELEMENT_LOST_FLAG_BIT, TX_EVENT_QUEUE_FULL_FLAG_BIT};
        axi_write(CONFIG_OFS, 32'h0000_0100);
        for (int i = 0; i < 4; i++)
        begin
            i_cmef_handler_model.fire(ev[i]);
            flags_are(32'h1 << bt[i]);
            check({31'h0, irq}, 32'h0, "irq masked");
            axi_write(MASK_OFS, 32'h1 << bt[i]);
            check({30'h0, bs}, {30'h0, RESP_OKAY}, "mask write resp");
            flags_are(32'h1 << bt[i]);
            check({31'h0, irq}, 32'h1, "irq unmasked");
            axi_write(FLAGS_OFS, 32'h1 << bt[i]);
            flags_are(32'h0);
            check({31'h0, irq}, 32'h0, "irq cleared");
        end
        axi_write(MASK_OFS, 32'h0);
        $display("test events done");
    endtask

    task automatic test_rx();
        i_cmef_handler_model.fire(10'h280);
        i_cmef_handler_model.fire(10'h100);
        flags_are(32'h1 << DRX_BIT);
        check(i_cmef_handler_model.new_data_cnt, 1, "new data");
        axi_write(FLAGS_OFS, FLAG_BITS);
        i_cmef_handler_model.fire(10'h280);
        i_cmef_handler_model.fire(10'h280);
        flags_are(32'h1 << MRF_BIT);
        check(i_cmef_handler_model.abort_cnt, 1, "overrun abort");
        check(i_cmef_handler_model.new_data_cnt, 1, "no commit on overrun");
        i_cmef_handler_model.fire(10'h100);
        repeat (2) @(posedge aclk);
        check(i_cmef_handler_model.new_data_cnt, 2, "next frame stored");
        axi_write(FLAGS_OFS, FLAG_BITS);
        i_cmef_handler_model.fire(10'h200);
        i_cmef_handler_model.fire(10'h100);
        axi_read(STATUS_OFS, rd, rs);
        check({26'h0, rd[5:0]}, 32'h1, "put index after commit");
        check(put_pulses, 1, "put pulse after commit");
        i_cmef_handler_model.fire(10'h200);
        i_cmef_handler_model.fire(10'h040);
        flags_are(32'h1 << MRF_BIT);
        check(i_cmef_handler_model.abort_cnt, 2, "write fail abort");
        i_cmef_handler_model.fire(10'h100);
        axi_read(STATUS_OFS, rd, rs);
        check({26'h0, rd[5:0]}, 32'h1, "put index after abort");
        check(put_pulses, 1, "no put pulse after abort");
        check(i_cmef_handler_model.new_data_cnt, 2, "no new data after abort");
        axi_write(FLAGS_OFS, FLAG_BITS);
        $display("test rx done");
    endtask

    task automatic test_tx_and_tef();
        i_cmef_handler_model.fire(10'h008);
        flags_are(32'h1 << MRF_BIT);
        check(i_cmef_handler_model.tx_abort_cnt, 1, "tx abort");
        check({31'h0, restricted_mode_control}, 32'h1, "restricted");
        axi_read(STATUS_OFS, rd, rs);
        check({31'h0, rd[STS_RESTRICT_BIT]}, 32'h1, "status restricted");
        axi_write(CONFIG_OFS, 32'h0000_0000, 4'h1);
        axi_read(CONFIG_OFS, rd, rs);
        check({26'h0, rd[CFG_TEF_SIZE_LSB +: 6]}, 32'h1, "size kept by lane");
        check({31'h0, restricted_mode_control}, 32'h0, "restricted left");
        axi_write(CONFIG_OFS, 32'h0000_0000);
        axi_write(FLAGS_OFS, FLAG_BITS);
        i_cmef_handler_model.fire(10'h004);
        flags_are(32'h1 << TX_EVENT_ELEMENT_LOST_FLAG_BIT);
        axi_write(FLAGS_OFS, 32'h1 << TX_EVENT_ELEMENT_LOST_FLAG_BIT);
        i_cmef_handler_model.fire(10'h001);
        flags_are(32'h0);
        $display("test tx and event queue done");
    endtask

    initial
    begin
        aresetn <= 1'b0;
        s_axi_awaddr <= 8'h00;
        s_axi_awvalid <= 1'b0;
        s_axi_wdata <= 32'h0000_0000;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_araddr <= 8'h00;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        test_reset_map();
        test_events();
        test_rx();
        test_tx_and_tef();
        give_verdict();
    end
endmodule
